// ---- bench/auc_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module auc_core_tb
	import auc_pkg::*;
;
	logic ref_clk;
	logic rst;
	auc_bus_t bus;
	logic [7:0] rdata_ff;
	logic serial_out_pin;
	logic serial_in_pin;
	auc_irq_t irq;
	logic en;
	logic msb;
	logic inv;
	logic [3:0] nb;
	int mismatches, total_checks, ntx, nrx, nerr, cyc;
	auc_core #(.DW(8)) i_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata_ff(rdata_ff),
		.serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin), .irq(irq));
	auc_remote #(.BIT(16)) i_far (.ref_clk(ref_clk), .line_in(serial_out_pin), .line_out(serial_in_pin),
		.en(en), .nb(nb), .msb(msb), .inv(inv));
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		ntx += irq.tx_done;
		nrx += irq.rx_done;
		nerr += irq.rx_err;
		cyc++;
		// Ten thousand cycles is more than twice the expected run
		if (cyc == 10000) begin
			mismatches++;
			close_out;
		end
	end
	task close_out;
		if (mismatches == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		// Idle edge so a following strobe is not raised where this one drops
		@(posedge ref_clk);
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		@(negedge ref_clk);
		d = rdata_ff;
		@(posedge ref_clk);
	endtask
	task wait_far(input int n);
		for (int i = 0; i < 800 && i_far.cnt < n; i++) @(posedge ref_clk);
	endtask
	task t_reset;
		logic [7:0] v;
		rd(AUC_IDX_TXBUF, v);
		chk("txbuf_rst", v, AUC_TXBUF_RST);
		rd(AUC_IDX_MODE1, v);
		chk("mode1_rst", v, AUC_MODE1_RST);
		rd(AUC_IDX_BAUD, v);
		chk("baud_rst", v, AUC_BAUD_RST);
		rd(4'hf, v);
		chk("unmapped", v, 8'h00);
		wr(AUC_IDX_BAUD, 8'h00);
		rd(AUC_IDX_BAUD, v);
		chk("baud_wr", v, 8'h00);
		wr(AUC_IDX_MODE0, 8'he0);
	endtask
	task t_frames;
		logic [1:0] cls [3];
		logic [7:0] m, td, rx;
		int c, x, r;
		cls = '{AUC_CL_5, AUC_CL_7, AUC_CL_8};
		for (int k = 0; k < 6; k++) begin
			nb = (k < 2) ? 4'h5 : (k < 4) ? 4'h7 : 4'h8;
			msb = 1'(k % 2);
			m = 8'((9'h1 << nb) - 9'h1);
			wr(AUC_IDX_MODE1, {3'h0, cls[k / 2], 1'b0, msb, 1'b0});
			td = 8'hc9 ^ 8'(k);
			c = i_far.cnt;
			x = ntx;
			r = nrx;
			fork
				i_far.send(~td);
				wr(AUC_IDX_TXBUF, td);
			join
			wait_far(c + 1);
			repeat (40) @(posedge ref_clk);
			chk("tx_data", i_far.got, td & m);
			chk("tx_irq", 8'(ntx - x), 8'h01);
			rd(AUC_IDX_RXBUF, rx);
			chk("rx_data", rx, ~td & m);
			chk("rx_irq", 8'(nrx - r), 8'h01);
		end
	endtask
	task t_b2b;
		logic [7:0] s;
		int x, c;
		nb = 4'h8;
		msb = 1'b0;
		x = ntx;
		c = i_far.cnt;
		wr(AUC_IDX_MODE1, 8'h18);
		wr(AUC_IDX_TXBUF, 8'ha1);
		s = 8'h10;
		for (int i = 0; i < 20 && s[AUC_ST_TXBF]; i++) rd(AUC_IDX_STAT, s);
		wr(AUC_IDX_TXBUF, 8'h3c);
		rd(AUC_IDX_STAT, s);
		chk("buf_full", 8'(s[AUC_ST_TXBF]), 8'h01);
		wait_far(c + 1);
		chk("first", i_far.got, 8'ha1);
		wait_far(c + 2);
		repeat (40) @(posedge ref_clk);
		chk("second", i_far.got, 8'h3c);
		chk("b2b_irq", 8'(ntx - x), 8'h02);
	endtask
	task t_over;
		logic [7:0] v;
		int e;
		e = nerr;
		i_far.send(8'h11);
		i_far.send(8'h22);
		repeat (40) @(posedge ref_clk);
		chk("ovr_irq", 8'(nerr - e), 8'h01);
		rd(AUC_IDX_RXBUF, v);
		chk("ovr_keep", v, 8'h11);
		rd(AUC_IDX_STAT, v);
		chk("ovr_flag", 8'(v[AUC_ST_OVE]), 8'h01);
	endtask
	task t_irqmode;
		int x, c;
		wr(AUC_IDX_MODE0, 8'he2);
		x = ntx;
		c = i_far.cnt;
		wr(AUC_IDX_TXBUF, 8'h55);
		repeat (4) @(posedge ref_clk);
		chk("empty_irq", 8'(ntx - x), 8'h01);
		wait_far(c + 1);
		repeat (40) @(posedge ref_clk);
		chk("no_done_irq", 8'(ntx - x), 8'h01);
		wr(AUC_IDX_MODE0, 8'he0);
	endtask
	task lat(input int gap, output int l);
		wr(AUC_IDX_MODE0, 8'ha0);
		repeat (3) @(posedge ref_clk);
		bus.addr <= AUC_IDX_MODE0;
		bus.wdata <= 8'he0;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		if (gap > 0) begin
			bus.wr <= 1'b0;
			repeat (gap) @(posedge ref_clk);
			bus.wr <= 1'b1;
		end
		bus.addr <= AUC_IDX_TXBUF;
		bus.wdata <= 8'h0f;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		l = 0;
		do begin
			@(posedge ref_clk);
			#1 l++;
		end while (serial_out_pin && l < 60);
		wait_far(i_far.cnt + 1);
		repeat (40) @(posedge ref_clk);
	endtask
	task t_loop;
		logic [7:0] v;
		int a, b, r, c;
		lat(3, a);
		lat(0, b);
		chk("early_start", 8'(b), 8'(a + 1));
		r = nrx;
		wr(AUC_IDX_MODE1, 8'h1c);
		wr(AUC_IDX_TXBUF, 8'h96);
		for (int i = 0; i < 800 && nrx == r; i++) @(posedge ref_clk);
		rd(AUC_IDX_RXBUF, v);
		chk("loopback", v, 8'h96);
		// Monitor is parked while the level flips, else it sees a false start
		en = 1'b0;
		wr(AUC_IDX_MODE1, 8'h19);
		inv <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("inv_idle", 8'(serial_out_pin), 8'h00);
		en = 1'b1;
		c = i_far.cnt;
		wr(AUC_IDX_TXBUF, 8'h4d);
		wait_far(c + 1);
		chk("inv_data", i_far.got, 8'h4d);
	endtask
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		{mismatches, total_checks, ntx, nrx, nerr, cyc} = '0;
		{en, msb, inv, nb} = {3'b100, 4'h8};
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset;
		t_frames;
		t_b2b;
		t_over;
		t_irqmode;
		t_loop;
		close_out;
	end
endmodule
`default_nettype wire

// ---- bench/auc_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module auc_remote #(
	parameter int BIT = 16
) (
	// Clock
	input wire logic ref_clk,
	// Serial lines
	input wire logic line_in,
	output logic line_out,
	// Frame format
	input wire logic en,
	input wire logic [3:0] nb,
	input wire logic msb,
	input wire logic inv
);
	logic [7:0] got;
	logic [7:0] sh;
	logic raw;
	int cnt;
	// Same inversion as the device, so the idle level follows the line polarity
	assign line_out = raw ^ inv;
	// Samples on the falling edge so the registered pin has settled
	initial begin
		raw = 1'b1;
		cnt = 0;
		got = 8'h00;
		forever begin
			@(negedge ref_clk);
			if (en && (line_in ^ inv) == 1'b0) begin
				repeat (BIT / 2) @(negedge ref_clk);
				sh = 8'h00;
				for (int i = 0; i < nb; i++) begin
					repeat (BIT) @(negedge ref_clk);
					if (msb) sh = {sh[6:0], line_in ^ inv};
					else sh[i] = line_in ^ inv;
				end
				repeat (BIT) @(negedge ref_clk);
				got = sh;
				cnt++;
			end
		end
	end
	// Idle line stays at mark level between frames
	task automatic send(input logic [7:0] d);
		raw <= 1'b0;
		repeat (BIT) @(posedge ref_clk);
		for (int i = 0; i < nb; i++) begin
			raw <= msb ? d[nb - 1 - i] : d[i];
			repeat (BIT) @(posedge ref_clk);
		end
		raw <= 1'b1;
		repeat (BIT) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ---- src/auc_core.sv ----
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module auc_core
	import auc_pkg::*;
#(
	parameter int DW = 8
) (
	// Operation clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire auc_bus_t bus,
	output logic [DW-1:0] rdata_ff,
	// Serial pins
	output logic serial_out_pin,
	input wire logic serial_in_pin,
	// Interrupt events
	output auc_irq_t irq
);
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11, TX_STOP = 2'b10} auc_tx_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10} auc_rx_t;

	logic [DW-1:0] transmit_buffer_ff, receive_buffer_ff, mode0_ff, mode1_ff, baud_ff;
	logic tx_buffer_full_flag_ff, overrun_error_flag_ff, ferr_ff, txe_d_ff, early_wr_ff;
	logic [7:0] baud_cnt_ff;
	logic tick;
	auc_tx_t tx_st_ff;
	auc_rx_t rx_st_ff;
	logic [3:0] tx_ovs_ff, rx_ovs_ff;
	logic [3:0] tx_bit_ff, rx_bit_ff;
	logic [DW-1:0] tx_q, rx_q;
	logic tx_line_ff, rx_in, rx_raw, load_tx, tx_shift, rx_shift, rx_clr;
	logic tx_done_ev, rx_done_ev, rx_err_ev, ovr_ev, wr_tx;
	logic en, txe, rxe, inv, msb, loop;
	logic [1:0] clen;
	logic [3:0] nbits;
	logic [DW-1:0] rx_val;

	assign en = mode0_ff[AUC_M0_EN];
	assign txe = en & mode0_ff[AUC_M0_TXE];
	assign rxe = en & mode0_ff[AUC_M0_RXE];
	assign inv = mode1_ff[AUC_M1_INV];
	assign msb = mode1_ff[AUC_M1_MSB];
	assign loop = mode1_ff[AUC_M1_LOOP];
	assign clen = mode1_ff[AUC_M1_CL0+1:AUC_M1_CL0];
	assign nbits = (clen == AUC_CL_8) ? 4'h8 : (clen == AUC_CL_7) ? 4'h7 : 4'h5;
	assign wr_tx = bus.wr && bus.addr == AUC_IDX_TXBUF;

	// Register writes; transmit buffer is the only path into the transmit shifter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			transmit_buffer_ff <= AUC_TXBUF_RST;
			mode0_ff <= '0;
			mode1_ff <= AUC_MODE1_RST;
			baud_ff <= AUC_BAUD_RST;
		end else if (bus.wr) begin
			unique case (bus.addr)
				AUC_IDX_TXBUF: transmit_buffer_ff <= bus.wdata;
				AUC_IDX_MODE0: mode0_ff <= bus.wdata & 8'he2;
				AUC_IDX_MODE1: mode1_ff <= bus.wdata & 8'h1f;
				AUC_IDX_BAUD: baud_ff <= bus.wdata;
				default: ;
			endcase
		end
	end

	// Reads; shift registers have no address
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= '0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				AUC_IDX_TXBUF: rdata_ff <= transmit_buffer_ff;
				AUC_IDX_RXBUF: rdata_ff <= receive_buffer_ff;
				AUC_IDX_MODE0: rdata_ff <= mode0_ff;
				AUC_IDX_MODE1: rdata_ff <= mode1_ff;
				AUC_IDX_BAUD: rdata_ff <= baud_ff;
				AUC_IDX_STAT: rdata_ff <= {2'h0, tx_st_ff != TX_IDLE, tx_buffer_full_flag_ff, 2'h0,
					ferr_ff, overrun_error_flag_ff};
				default: rdata_ff <= '0;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	// Baud generator: tick every baud_ff+1 clocks, sixteen ticks per bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			baud_cnt_ff <= '0;
		end else if (!en || tick) begin
			baud_cnt_ff <= '0;
		end else begin
			baud_cnt_ff <= baud_cnt_ff + 8'h01;
		end
	end
	assign tick = en && baud_cnt_ff == baud_ff;

	// Enable seen last cycle; a write right after enable waits one extra cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			txe_d_ff <= 1'b0;
			early_wr_ff <= 1'b0;
		end else begin
			txe_d_ff <= txe;
			early_wr_ff <= wr_tx && txe && !txe_d_ff;
		end
	end

	// Buffer full flag: set by write wins over clear by load
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_buffer_full_flag_ff <= 1'b0;
		end else if (!txe) begin
			tx_buffer_full_flag_ff <= 1'b0;
		end else if (wr_tx) begin
			tx_buffer_full_flag_ff <= 1'b1;
		end else if (load_tx) begin
			tx_buffer_full_flag_ff <= 1'b0;
		end
	end

	// Load in idle as soon as the buffer holds data, or at frame end
	assign load_tx = tx_buffer_full_flag_ff && txe_d_ff && !early_wr_ff &&
		(tx_st_ff == TX_IDLE || (tx_st_ff == TX_STOP && tick && tx_ovs_ff == AUC_OVS_LAST));
	// Short characters: unused upper bits never leave the shifter
	assign tx_shift = tx_st_ff == TX_DATA && tick && tx_ovs_ff == AUC_OVS_LAST;

	auc_shift #(.W(DW)) u_tx_shift (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(!txe),
		.load(load_tx),
		.load_val(msb ? (transmit_buffer_ff << (4'h8 - nbits)) : transmit_buffer_ff),
		.shift(tx_shift),
		.msb_first(msb),
		.in_bit(1'b0),
		.q_ff(tx_q)
	);

	// Transmit frame sequencer, separate from the receiver
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_st_ff <= TX_IDLE;
			tx_ovs_ff <= '0;
			tx_bit_ff <= '0;
		end else if (!txe) begin
			tx_st_ff <= TX_IDLE;
			tx_ovs_ff <= '0;
			tx_bit_ff <= '0;
		end else if (load_tx) begin
			tx_st_ff <= TX_START;
			tx_ovs_ff <= '0;
			tx_bit_ff <= '0;
		end else if (tick) begin
			tx_ovs_ff <= tx_ovs_ff + 4'h1;
			if (tx_ovs_ff == AUC_OVS_LAST) begin
				unique case (tx_st_ff)
					TX_START: tx_st_ff <= TX_DATA;
					TX_DATA: begin
						tx_bit_ff <= tx_bit_ff + 4'h1;
						if (tx_bit_ff == nbits - 4'h1) begin
							tx_st_ff <= TX_STOP;
						end
					end
					TX_STOP: tx_st_ff <= TX_IDLE;
					TX_IDLE: ;
				endcase
			end
		end
	end

	// Line is registered; idle and stop are mark
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_line_ff <= 1'b1;
		end else begin
			unique case (tx_st_ff)
				TX_START: tx_line_ff <= 1'b0;
				TX_DATA: tx_line_ff <= msb ? tx_q[DW-1] : tx_q[0];
				default: tx_line_ff <= 1'b1;
			endcase
		end
	end
	assign serial_out_pin = tx_line_ff ^ inv;

	assign tx_done_ev = tick && tx_st_ff == TX_STOP && tx_ovs_ff == AUC_OVS_LAST;
	// Mode 1 reports buffer empty at load so software can refill during the frame
	assign irq.tx_done = mode0_ff[AUC_M0_ISSM] ? load_tx : tx_done_ev;

	// Receive side; loopback taps the line before inversion so polarity cancels
	assign rx_raw = loop ? tx_line_ff : (serial_in_pin ^ inv);
	assign rx_in = rx_raw;
	assign rx_shift = rx_st_ff == RX_DATA && tick && rx_ovs_ff == AUC_OVS_MID;
	assign rx_clr = !rxe || (rx_st_ff == RX_IDLE);

	auc_shift #(.W(DW)) u_rx_shift (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(rx_clr),
		.load(1'b0),
		.load_val('0),
		.shift(rx_shift),
		.msb_first(msb),
		.in_bit(rx_in),
		.q_ff(rx_q)
	);

	// LSB-first data lands at the top; move it down for short characters
	assign rx_val = msb ? rx_q : (rx_q >> (4'h8 - nbits));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_st_ff <= RX_IDLE;
			rx_ovs_ff <= '0;
			rx_bit_ff <= '0;
		end else if (!rxe) begin
			rx_st_ff <= RX_IDLE;
			rx_ovs_ff <= '0;
			rx_bit_ff <= '0;
		end else if (tick) begin
			rx_ovs_ff <= rx_ovs_ff + 4'h1;
			unique case (rx_st_ff)
				RX_IDLE: begin
					rx_ovs_ff <= '0;
					rx_bit_ff <= '0;
					if (!rx_in) begin
						rx_st_ff <= RX_START;
					end
				end
				RX_START: begin
					if (rx_ovs_ff == AUC_OVS_MID && rx_in) begin
						rx_st_ff <= RX_IDLE;
					end else if (rx_ovs_ff == AUC_OVS_LAST) begin
						rx_st_ff <= RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_ovs_ff == AUC_OVS_LAST) begin
						rx_bit_ff <= rx_bit_ff + 4'h1;
						if (rx_bit_ff == nbits - 4'h1) begin
							rx_st_ff <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_ovs_ff == AUC_OVS_MID) begin
						rx_st_ff <= RX_IDLE;
					end
				end
			endcase
		end
	end

	logic rx_unread_ff;
	assign rx_done_ev = tick && rx_st_ff == RX_STOP && rx_ovs_ff == AUC_OVS_MID;
	assign ovr_ev = rx_done_ev && rx_unread_ff;
	assign rx_err_ev = rx_done_ev && (!rx_in || rx_unread_ff);

	// Receive buffer kept on overrun; cleared when the block is disabled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			receive_buffer_ff <= '0;
		end else if (!en) begin
			receive_buffer_ff <= '0;
		end else if (rx_done_ev && !ovr_ev) begin
			receive_buffer_ff <= rx_val;
		end
	end

	// Unread and error flags: new event wins over a same-cycle read clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_unread_ff <= 1'b0;
			overrun_error_flag_ff <= 1'b0;
			ferr_ff <= 1'b0;
		end else if (!en) begin
			rx_unread_ff <= 1'b0;
			overrun_error_flag_ff <= 1'b0;
			ferr_ff <= 1'b0;
		end else begin
			if (rx_done_ev) begin
				rx_unread_ff <= 1'b1;
			end else if (bus.rd && bus.addr == AUC_IDX_RXBUF) begin
				rx_unread_ff <= 1'b0;
			end
			if (ovr_ev) begin
				overrun_error_flag_ff <= 1'b1;
			end else if (bus.rd && bus.addr == AUC_IDX_STAT) begin
				overrun_error_flag_ff <= 1'b0;
			end
			if (rx_done_ev && !rx_in) begin
				ferr_ff <= 1'b1;
			end else if (bus.rd && bus.addr == AUC_IDX_STAT) begin
				ferr_ff <= 1'b0;
			end
		end
	end

	assign irq.rx_done = rx_done_ev && !rx_err_ev;
	assign irq.rx_err = rx_err_ev;

	a_ovr_nostore: assert property (@(posedge ref_clk) disable iff (rst)
		ovr_ev |=> $stable(receive_buffer_ff)) else $error("overrun stored data");
	a_write_full: assert property (@(posedge ref_clk) disable iff (rst)
		(wr_tx && txe) |=> tx_buffer_full_flag_ff) else $error("write did not set full");
	a_start_low: assert property (@(posedge ref_clk) disable iff (rst)
		(load_tx && !inv && txe) |=> ##1 !serial_out_pin) else $error("no start bit");
	a_idle_mark: assert property (@(posedge ref_clk) disable iff (rst)
		(tx_st_ff == TX_IDLE && $past(tx_st_ff) == TX_IDLE) |-> serial_out_pin == !inv) else $error("idle level");
	a_short_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(clen == AUC_CL_5 && $stable(clen)) |-> receive_buffer_ff[7:5] == 3'h0 || $changed(receive_buffer_ff) == 0)
		else $error("upper bits not zero");
	a_load_early: assert property (@(posedge ref_clk) disable iff (rst)
		(wr_tx && txe && !txe_d_ff) |=> !load_tx ##1 (load_tx || !txe)) else $error("early write not delayed");
	a_irq_mode: assert property (@(posedge ref_clk) disable iff (rst)
		(!mode0_ff[AUC_M0_ISSM] && irq.tx_done) |-> tx_st_ff == TX_STOP) else $error("tx irq timing");
	a_err_excl: assert property (@(posedge ref_clk) disable iff (rst)
		!(irq.rx_done && irq.rx_err)) else $error("rx irq both");
	a_loop_route: assert property (@(posedge ref_clk) disable iff (rst)
		loop |-> rx_raw == tx_line_ff) else $error("loopback path");
endmodule
`default_nettype wire

// ---- src/auc_pkg.sv ----
package auc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] AUC_IDX_TXBUF = 4'h0;
	localparam logic [3:0] AUC_IDX_RXBUF = 4'h1;
	localparam logic [3:0] AUC_IDX_MODE0 = 4'h2;
	localparam logic [3:0] AUC_IDX_MODE1 = 4'h3;
	localparam logic [3:0] AUC_IDX_BAUD = 4'h4;
	localparam logic [3:0] AUC_IDX_STAT = 4'h5;
	localparam logic [7:0] AUC_TXBUF_RST = 8'hff;
	localparam logic [7:0] AUC_BAUD_RST = 8'h0f;
	// Mode 0 fields
	localparam int AUC_M0_ISSM = 1;
	localparam int AUC_M0_RXE = 5;
	localparam int AUC_M0_TXE = 6;
	localparam int AUC_M0_EN = 7;
	// Mode 1 fields
	localparam int AUC_M1_INV = 0;
	localparam int AUC_M1_MSB = 1;
	localparam int AUC_M1_LOOP = 2;
	localparam int AUC_M1_CL0 = 3;
	localparam logic [7:0] AUC_MODE1_RST = 8'h1a;
	// Status fields
	localparam int AUC_ST_OVE = 0;
	localparam int AUC_ST_FE = 1;
	localparam int AUC_ST_TXBF = 4;
	localparam int AUC_ST_TXSF = 5;
	// Character length codes
	localparam logic [1:0] AUC_CL_5 = 2'h0;
	localparam logic [1:0] AUC_CL_7 = 2'h2;
	localparam logic [1:0] AUC_CL_8 = 2'h3;
	localparam int AUC_OVS = 16;
	localparam logic [3:0] AUC_OVS_MID = 4'h7;
	localparam logic [3:0] AUC_OVS_LAST = 4'hf;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} auc_bus_t;
	typedef struct packed {
		logic tx_done;
		logic rx_done;
		logic rx_err;
	} auc_irq_t;
endpackage

// ---- src/auc_shift.sv ----
`timescale 1ns/1ps
`default_nettype none
module auc_shift
	import auc_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic clr,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic shift,
	input wire logic msb_first,
	input wire logic in_bit,
	// State
	output logic [W-1:0] q_ff
);
	// One register serves both directions: out bit is the end selected by bit order
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q_ff <= '0;
		end else if (clr) begin
			q_ff <= '0;
		end else if (load) begin
			q_ff <= load_val;
		end else if (shift) begin
			if (msb_first) begin
				q_ff <= {q_ff[W-2:0], in_bit};
			end else begin
				q_ff <= {in_bit, q_ff[W-1:1]};
			end
		end
	end
endmodule
`default_nettype wire
